// *** isdt_top.sv ***
// interrupt split descriptor tracker: masks, IN byte slots, results
// assumes a single AHB-Lite master and link events synchronous to clk
`default_nettype none

module isdt_top
  import isdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire isdt_link_in_s linkIn,
  output isdt_issue_s issue,
  output logic haltFlag,
  output logic babbleFlag,
  output logic errorFlag,
  output logic irq
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdData_q;
  logic [7:0] ssMask_q, csMask_q, armed_q;
  logic cfgOut_q;
  logic [4:0] cfgFrame_q;
  logic [23:0] result_q;
  logic [63:0] inSlot_q;
  logic [2:0] curUf_q;
  logic [1:0] irqStat_q, irqEn_q;
  isdt_issue_s issue_q;

  function automatic logic [7:0] ufBit(input logic [2:0] uf);
    ufBit = 8'h01 << uf;
  endfunction : ufBit

  wire addrPhase = hsel && hready && htrans[1];
  wire rdReq = addrPhase && !hwrite;
  wire wrReq = addrPhase && hwrite;
  wire wrMasks = wrPend_q && wrAddr_q == ADDR_MASKS;
  wire wrConfig = wrPend_q && wrAddr_q == ADDR_CONFIG;
  wire wrIrqClr = wrPend_q && wrAddr_q == ADDR_IRQ_CLR;
  wire wrIrqEn = wrPend_q && wrAddr_q == ADDR_IRQ_EN;
  // software may only raise mask bits; zeros written leave bits alone
  wire [7:0] ssSet = wrMasks ? hwdata[7:0] : 8'h00;
  wire [7:0] csSet = wrMasks ? hwdata[CS_LSB +: 8] : 8'h00;

  // ----------------------------------------------------------------
  // microframe scheduling
  // ----------------------------------------------------------------
  wire frameMatch = linkIn.frameNum == cfgFrame_q;
  wire [7:0] ufOne = ufBit(linkIn.uframe);
  wire ufInOk = linkIn.uframe < 3'(IN_UFRAMES);
  wire ssHit = linkIn.sof && |(ssMask_q & ufOne) && frameMatch
    && (cfgOut_q || ufInOk);
  wire csHit = linkIn.sof && |(csMask_q & ufOne) && !cfgOut_q;
  wire [7:0] ssClr = ssHit ? ufOne : 8'h00;
  wire [7:0] csClr = csHit ? ufOne : 8'h00;
  // set wins over the clear in the same cycle
  wire [7:0] ssMask_d = (ssMask_q & ~ssClr) | ssSet;
  wire [7:0] csMask_d = (csMask_q & ~csClr) | csSet;
  // byte capture keeps its own arming copy: the start mask bit is gone
  // by the time the split returns data
  wire [7:0] armed_d = wrMasks ? hwdata[7:0] : armed_q;
  wire rxStore = linkIn.rxValid && armed_q[curUf_q] && frameMatch;

  // ----------------------------------------------------------------
  // result fields and summaries
  // ----------------------------------------------------------------
  wire [2:0] resCode = cfgOut_q ? (linkIn.resCode & ~3'(1 << RES_BABBLE))
    : linkIn.resCode;
  logic [7:0] errBits, babBits, haltBits;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      errBits[i] = result_q[3 * i + RES_ERR];
      babBits[i] = result_q[3 * i + RES_BABBLE];
      haltBits[i] = result_q[3 * i + RES_HALT];
    end
  end
  assign babbleFlag = |babBits;
  assign errorFlag = |errBits;
  assign haltFlag = |haltBits;

  wire [1:0] irqEvt = {linkIn.resValid && |resCode, ssHit || csHit};
  wire [1:0] irqClr = wrIrqClr ? hwdata[1:0] : 2'h0;
  wire [1:0] irqStat_d = (irqStat_q & ~irqClr) | irqEvt;
  assign irq = |(irqStat_q & irqEn_q);

  // ----------------------------------------------------------------
  // read mux; reserved bits read zero
  // ----------------------------------------------------------------
  wire [7:0] rdAddr = haddr[7:0];
  wire [31:0] rdMux =
    rdAddr == ADDR_MASKS ? {16'h0000, csMask_q, ssMask_q} :
    rdAddr == ADDR_CONFIG ? {26'h0, cfgFrame_q, cfgOut_q} :
    rdAddr == ADDR_RESULT ? {5'h00, errorFlag, babbleFlag, haltFlag, result_q} :
    rdAddr == ADDR_IN_LO ? inSlot_q[31:0] :
    rdAddr == ADDR_IN_HI ? inSlot_q[63:32] :
    rdAddr == ADDR_IRQ_STAT ? {30'h0, irqStat_q} :
    rdAddr == ADDR_IRQ_EN ? {30'h0, irqEn_q} : 32'h0000_0000;

  assign hrdata = rdData_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign issue = issue_q;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdData_q <= 32'h0000_0000;
    end
    else
    begin
      wrPend_q <= wrReq;
      wrAddr_q <= haddr[7:0];
      if (rdReq)
        rdData_q <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ssMask_q <= MASK_RESET;
      csMask_q <= MASK_RESET;
      armed_q <= MASK_RESET;
      cfgOut_q <= 1'b0;
      cfgFrame_q <= 5'h00;
      irqStat_q <= IRQ_RESET;
      irqEn_q <= IRQ_RESET;
    end
    else
    begin
      ssMask_q <= ssMask_d;
      csMask_q <= csMask_d;
      armed_q <= armed_d;
      irqStat_q <= irqStat_d;
      if (wrConfig)
      begin
        cfgOut_q <= hwdata[CFG_OUT_BIT];
        cfgFrame_q <= hwdata[CFG_FRAME_LSB +: 5];
      end
      if (wrIrqEn)
        irqEn_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      curUf_q <= 3'h0;
      issue_q <= '0;
      inSlot_q <= 64'h0;
      result_q <= 24'h000000;
    end
    else
    begin
      if (linkIn.sof)
        curUf_q <= linkIn.uframe;
      issue_q <= '{startSplit: ssHit, completeSplit: csHit, uframe: linkIn.uframe};
      if (rxStore)
        inSlot_q[8 * curUf_q +: 8] <= linkIn.rxByte;
      if (linkIn.resValid)
        result_q[3 * curUf_q +: 3] <= resCode;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_issue: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.sof && ssMask_q[linkIn.uframe] && frameMatch && (cfgOut_q || ufInOk)
    |=> issue.startSplit && issue.uframe == $past(linkIn.uframe))
    else $error("start split not issued");

  a_in_high_block: assert property (@(posedge clk) disable iff (!reset_n)
    issue.startSplit && issue.uframe >= 3'(IN_UFRAMES) |-> $past(cfgOut_q))
    else $error("IN start split beyond microframe 3");

  a_in_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.sof && !cfgOut_q && !ufInOk |=> !issue.startSplit)
    else $error("IN start split in a late microframe");

  a_ss_frame: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.sof && !frameMatch |=> !issue.startSplit)
    else $error("start split on wrong frame");

  // mask bits only fall on a processed microframe; software writes always land
  a_ss_clear: assert property (@(posedge clk) disable iff (!reset_n)
    ssHit && !ssSet[linkIn.uframe] |=> !ssMask_q[$past(linkIn.uframe)])
    else $error("start mask bit not cleared");

  a_ss_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !ssHit |=> (ssMask_q & $past(ssMask_q)) == $past(ssMask_q))
    else $error("start mask bit lost without split");

  a_ss_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    wrMasks |=> (ssMask_q & $past(hwdata[7:0])) == $past(hwdata[7:0]))
    else $error("start mask write lost");

  a_cs_clear: assert property (@(posedge clk) disable iff (!reset_n)
    csHit && !csSet[linkIn.uframe]
    |=> !csMask_q[$past(linkIn.uframe)] && issue.completeSplit)
    else $error("complete mask bit not cleared");

  a_cs_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !csHit |=> (csMask_q & $past(csMask_q)) == $past(csMask_q))
    else $error("complete mask bit lost without split");

  a_cs_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    wrMasks |=> (csMask_q & $past(hwdata[CS_LSB +: 8])) == $past(hwdata[CS_LSB +: 8]))
    else $error("complete mask write lost");

  a_cs_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.sof && !csMask_q[linkIn.uframe] |=> !issue.completeSplit)
    else $error("complete split without mask bit");

  a_cs_in_only: assert property (@(posedge clk) disable iff (!reset_n)
    issue.completeSplit |-> !$past(cfgOut_q))
    else $error("complete split on OUT transfer");

  a_example_seq: assert property (@(posedge clk) disable iff (!reset_n)
    ssMask_q == 8'h01 && csMask_q == 8'h04 && !cfgOut_q && frameMatch
    && linkIn.sof && linkIn.uframe == 3'h0
    |=> issue.startSplit && !issue.completeSplit)
    else $error("example start split mismatch");

  a_example_cs: assert property (@(posedge clk) disable iff (!reset_n)
    ssMask_q == 8'h00 && csMask_q == 8'h04 && !cfgOut_q
    && linkIn.sof && linkIn.uframe == 3'h2
    |=> !issue.startSplit && issue.completeSplit)
    else $error("example complete split mismatch");

  a_byte_store: assert property (@(posedge clk) disable iff (!reset_n)
    rxStore |=> inSlot_q[8 * $past(curUf_q) +: 8] == $past(linkIn.rxByte))
    else $error("IN byte not stored");

  a_byte_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !rxStore |=> $stable(inSlot_q))
    else $error("IN slot changed without armed byte");

  a_byte_frame: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.rxValid && !frameMatch |=> $stable(inSlot_q))
    else $error("IN byte stored on wrong frame");

  a_result_field: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.resValid |=> result_q[3 * $past(curUf_q) +: 3] == $past(resCode))
    else $error("result field not written");

  a_result_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !linkIn.resValid |=> $stable(result_q))
    else $error("result changed without link result");

  a_err_flag: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.resValid && linkIn.resCode[RES_ERR] |=> errorFlag)
    else $error("error summary missed");

  a_babble_out: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.resValid && cfgOut_q |=> !result_q[3 * $past(curUf_q) + RES_BABBLE])
    else $error("babble recorded on OUT");

  a_babble_flag: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.resValid && !cfgOut_q && linkIn.resCode[RES_BABBLE] |=> babbleFlag)
    else $error("babble summary missed");

  a_err_clear: assert property (@(posedge clk) disable iff (!reset_n)
    result_q == 24'h0 |-> !errorFlag && !babbleFlag)
    else $error("summary set with clean results");

  a_halt_flag: assert property (@(posedge clk) disable iff (!reset_n)
    linkIn.resValid && linkIn.resCode[RES_HALT] |=> haltFlag)
    else $error("halt flag missed");

  a_rsvd_read: assert property (@(posedge clk) disable iff (!reset_n)
    rdReq && haddr[7:0] == ADDR_RESULT |=> hrdata[31:27] == 5'h00)
    else $error("reserved result bits read nonzero");

  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    irqEvt[IRQ_FAULT] && irqEn_q[IRQ_FAULT] && !wrIrqEn |=> irq)
    else $error("interrupt not raised");

  // interrupt status: an event in the clearing cycle survives the clear
  a_irq_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    irqEvt[IRQ_SPLIT] |=> irqStat_q[IRQ_SPLIT])
    else $error("split event lost");

  a_irq_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wrIrqClr && hwdata[IRQ_FAULT] && !irqEvt[IRQ_FAULT] |=> !irqStat_q[IRQ_FAULT])
    else $error("fault status not cleared");
endmodule : isdt_top

`default_nettype wire

// *** isdt_pkg.sv ***
// constants and carrier types for the interrupt split descriptor tracker
// assumes an AHB-Lite register bus and a link engine on the same clock
//
// Functional notes
// - store IN byte per armed, frame-matched microframe
// - each IN byte slot overwritten, no history
// - complete mask: software sets, hardware clears
// - complete splits for IN only, any bits
// - start mask 01, complete 04: SS0, CS2
// - 3-bit result per microframe, 7 highest
// - result bit 0 marks transaction error
// - result bit 1 marks babble, IN only
// - start mask set/cleared; IN limited to 0-3
// - summary babble from all result bit 1
// - summary error from all result bit 0
// - halt flag on any halted result
`default_nettype none

package isdt_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASKS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_IN_LO = 8'h0C;
  localparam logic [7:0] ADDR_IN_HI = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CS_LSB = 8;
  localparam int CFG_OUT_BIT = 0;
  localparam int CFG_FRAME_LSB = 1;
  localparam int SUM_HALT_BIT = 24;
  localparam int SUM_BABBLE_BIT = 25;
  localparam int SUM_ERR_BIT = 26;
  localparam int RES_ERR = 0;
  localparam int RES_BABBLE = 1;
  localparam int RES_HALT = 2;
  localparam int IRQ_SPLIT = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IN_UFRAMES = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sof;
    logic [2:0] uframe;
    logic [4:0] frameNum;
    logic rxValid;
    logic [7:0] rxByte;
    logic resValid;
    logic [2:0] resCode;
  } isdt_link_in_s;

  typedef struct packed {
    logic startSplit;
    logic completeSplit;
    logic [2:0] uframe;
  } isdt_issue_s;
endpackage : isdt_pkg

`default_nettype wire

// *** isdt_hub_model.sv ***
// far-side model: hub translator and downstream device
// assumes issue pulses from the tracker on the same clock
`default_nettype none

module isdt_hub_model
  import isdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire isdt_issue_s issue,
  input wire logic [7:0] byteBase,
  input wire logic [23:0] codeMap,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic resValid,
  output logic [2:0] resCode
);
  timeunit 1ns;
  timeprecision 1ps;
  // each cycle with a split gets one byte and one result, one cycle later, even when start and complete issue together
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      rxValid <= 1'b0;
      resValid <= 1'b0;
      rxByte <= 8'h00;
      resCode <= 3'h0;
    end
    else if (issue.startSplit || issue.completeSplit)
    begin
      rxValid <= 1'b1;
      rxByte <= byteBase + 8'(issue.uframe);
      resValid <= 1'b1;
      resCode <= 3'(codeMap >> (3 * issue.uframe));
    end
    else
    begin
      rxValid <= 1'b0;
      resValid <= 1'b0;
      // released lines toggle so a stale byte is never mistaken for data
      rxByte <= ~rxByte;
      resCode <= ~resCode;
    end
endmodule : isdt_hub_model

`default_nettype wire

// *** tb_interrupt_split_descriptor_tracker.sv ***
// bench: AHB-Lite register calls plus microframe sequences
// assumes zero-wait slave and the hub model on the link side
`default_nettype none

module tb_interrupt_split_descriptor_tracker
  import isdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, sof;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, uf, pResC;
  logic [4:0] fnum;
  logic [7:0] base, ssSeen, csSeen, pRxB;
  logic [23:0] codes;
  logic haltFlag, babbleFlag, errorFlag, irq, pRxV, pResV;
  isdt_link_in_s linkIn;
  isdt_issue_s issue;
  int fail_count, comparisons;
  assign hready = hreadyout;
  assign linkIn = {sof, uf, fnum, pRxV, pRxB, pResV, pResC};
  isdt_top dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .linkIn(linkIn), .issue(issue), .haltFlag(haltFlag), .babbleFlag(babbleFlag), .errorFlag(errorFlag),
    .irq(irq));
  isdt_hub_model hub (.clk(clk), .reset_n(reset_n), .issue(issue), .byteBase(base), .codeMap(codes),
    .rxValid(pRxV), .rxByte(pRxB), .resValid(pResV), .resCode(pResC));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (issue.startSplit === 1'b1) ssSeen[issue.uframe] <= 1'b1;
    if (issue.completeSplit === 1'b1) csSeen[issue.uframe] <= 1'b1;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic hwait;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask : hwait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00, a};
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
    chk("response", hresp, 32'h0);
  endtask : rdchk
  // eight microframes of one frame, sof spaced by six cycles
  task automatic frame(input logic [4:0] f);
    ssSeen = 8'h00;
    csSeen = 8'h00;
    for (int u = 0; u < 8; u++)
    begin
      @(posedge clk);
      sof <= 1'b1;
      uf <= 3'(u);
      fnum <= f;
      @(posedge clk);
      sof <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : frame
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hsel, hwrite, sof, base, codes, haddr, hwdata, htrans, uf, fnum, ssSeen, csSeen, reset_n} = '0;
    hsize = 3'h2;
    fail_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk("reset outputs", {issue, haltFlag, babbleFlag, errorFlag, irq, hreadyout, hresp}, 32'h2);
    chk("reset read data", hrdata, 32'h0);
    rdchk("masks", ADDR_MASKS, 32'h0);
    bus(1'b1, ADDR_RESULT, 32'hFFFFFFFF);
    rdchk("result", ADDR_RESULT, 32'h0);
    rdchk("unmapped", 8'h24, 32'h0);
    $display("test reset done");
    bus(1'b1, ADDR_CONFIG, 32'h6);
    bus(1'b1, ADDR_MASKS, 32'h0401);
    base = 8'hA0;
    codes = 24'h000001;
    frame(5'h03);
    chk("start map", ssSeen, 32'h01);
    chk("complete map", csSeen, 32'h04);
    rdchk("masks", ADDR_MASKS, 32'h0);
    rdchk("in low", ADDR_IN_LO, 32'hA0);
    rdchk("result", ADDR_RESULT, 32'h04000001);
    chk("irq off", irq, 32'h0);
    rdchk("irq stat", ADDR_IRQ_STAT, 32'h3);
    bus(1'b1, ADDR_IRQ_EN, 32'h3);
    rdchk("irq en", ADDR_IRQ_EN, 32'h3);
    chk("irq on", irq, 32'h1);
    bus(1'b1, ADDR_IRQ_CLR, 32'h3);
    rdchk("irq stat", ADDR_IRQ_STAT, 32'h0);
    chk("irq off", irq, 32'h0);
    $display("test single split done");
    bus(1'b1, ADDR_MASKS, 32'hFFFF);
    base = 8'h10;
    codes = 24'hFAC688;
    frame(5'h03);
    chk("start map", ssSeen, 32'h0F);
    chk("complete map", csSeen, 32'hFF);
    rdchk("in low", ADDR_IN_LO, 32'h13121110);
    rdchk("in high", ADDR_IN_HI, 32'h17161514);
    rdchk("result", ADDR_RESULT, 32'h07FAC688);
    chk("flags", {haltFlag, babbleFlag, errorFlag}, 32'h7);
    bus(1'b1, ADDR_MASKS, 32'hFFFF);
    base = 8'h50;
    codes = 24'h0;
    frame(5'h03);
    rdchk("in low", ADDR_IN_LO, 32'h53525150);
    rdchk("result", ADDR_RESULT, 32'h0);
    chk("flags", {haltFlag, babbleFlag, errorFlag}, 32'h0);
    $display("test all microframes done");
    bus(1'b1, ADDR_CONFIG, 32'hA);
    bus(1'b1, ADDR_MASKS, 32'hFFFF);
    base = 8'h70;
    frame(5'h03);
    chk("start map", ssSeen, 32'h00);
    rdchk("in low", ADDR_IN_LO, 32'h53525150);
    rdchk("masks", ADDR_MASKS, 32'h00FF);
    bus(1'b1, ADDR_CONFIG, 32'h7);
    bus(1'b1, ADDR_MASKS, 32'hFF00);
    codes = 24'h6DB6DB;
    frame(5'h03);
    chk("start map", ssSeen, 32'hFF);
    chk("complete map", csSeen, 32'h00);
    rdchk("result", ADDR_RESULT, 32'h04249249);
    chk("babble", babbleFlag, 32'h0);
    $display("test frame and direction done");
    tally_and_finish();
  end
endmodule : tb_interrupt_split_descriptor_tracker

`default_nettype wire
